// file: hw/rsfb_top.sv
// Shared host and state machine FIFO buffer with alerts and interrupt
`default_nettype none
module rsfb_top #(
  parameter int DEPTH = 512
) (
  // Clock and reset
  input  wire logic       CLK,
  input  wire logic       RST_B,
  // Host register port
  input  wire logic [6:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output var  logic [7:0] RDATA,
  // Internal command state machine port
  input  wire logic       SM_WR,
  input  wire logic [7:0] SM_WDATA,
  input  wire logic       SM_RD,
  output var  logic [7:0] SM_RDATA,
  output var  logic       SM_ACTIVE,
  // Interrupt pin
  output var  logic       IRQ
);
  // ==========================================================
  // Elaboration check
  if (DEPTH != 512)
  begin : g_bad_depth
    $error("rsfb_top serves a depth of 512 only");
  end

  // ==========================================================
  // Storage and state
  logic [7:0] mem_q [0:DEPTH-1];
  logic [8:0] wptr_q;
  logic [8:0] rptr_q;
  logic [9:0] count_q;
  logic       short_q;
  logic [8:0] thresh_q;
  logic       hi_q;
  logic       lo_q;
  logic [3:0] ev_q;
  logic [3:0] en_q;
  logic       sm_act_q;
  logic [7:0] rdata_q;
  logic [7:0] smrd_q;
  logic       irq_q;

  // Address decode
  // Register map seen by the host:
  //   0x02 control: size select, alert flags, flush, threshold and fill high bits
  //   0x03 threshold low byte
  //   0x04 fill count low byte
  //   0x05 data window into the buffer
  //   0x06 sticky events, write one to clear
  //   0x08 event enables, same layout as the events
  //   0x0a command running flag for the internal machine
  // Writing the control register always rewrites the size select and the
  // threshold high bit, so software must carry them along with a flush.
  // Unmapped addresses read zero and ignore writes.
  // The fill count reaches 512 in long mode, one more than nine bits hold;
  // a completely full long buffer therefore reads a fill of zero, and the
  // almost-full flag is the reliable sign that it is full.
  wire        wr_ctrl = WR && (ADDR == rsfb_pkg::REG_FIFO_CTRL);
  wire        wr_data = WR && (ADDR == rsfb_pkg::REG_FIFO_DATA);
  wire        rd_data = RD && (ADDR == rsfb_pkg::REG_FIFO_DATA);
  wire        flush   = wr_ctrl && WDATA[rsfb_pkg::CTRL_FLUSH_BIT];
  // Depth in use follows the size select
  wire [9:0]  depth   = short_q ? rsfb_pkg::DEPTH_SHORT : rsfb_pkg::DEPTH_LONG;
  wire        full    = (count_q >= depth);
  wire        empty   = (count_q == 10'h000);
  // Host has priority; the state machine uses the same pointers, so the
  // host must keep off the buffer while a command moves data
  wire        push_h  = wr_data && !full;
  wire        push_s  = SM_WR && !wr_data && !full;
  wire        push    = push_h || push_s;
  wire [7:0]  push_d  = push_h ? WDATA : SM_WDATA;
  wire        pop_h   = rd_data && !empty;
  wire        pop_s   = SM_RD && !rd_data && !empty;
  wire        pop     = pop_h || pop_s;
  wire        ovl     = wr_data && full;

  // Pointer wrap at the active depth
  function automatic logic [8:0] ptr_inc(input logic [8:0] p, input logic s);
    ptr_inc = (s && p == 9'h0fe) ? 9'h000 : p + 9'h001;
  endfunction

  // Alerts from the current fill, size and single threshold
  wire [9:0]  free_sp = depth - count_q;
  wire        hi_d    = (free_sp <= {1'b0, thresh_q});
  wire        lo_d    = (count_q <= {1'b0, thresh_q});
  wire        hi_rise = hi_d && !hi_q;
  wire        lo_rise = lo_d && !lo_q;

  // Register read mux; reserved bits read zero
  wire [7:0]  ctrl_rd = {short_q, hi_q, lo_q, 2'b00, thresh_q[8], 1'b0,
                         short_q ? 1'b0 : count_q[8]};
  wire [7:0]  len_rd  = short_q ? count_q[7:0] : count_q[7:0];
  wire [7:0]  rd_mux  =
      (ADDR == rsfb_pkg::REG_FIFO_CTRL)  ? ctrl_rd :
      (ADDR == rsfb_pkg::REG_THRESH_LOW) ? thresh_q[7:0] :
      (ADDR == rsfb_pkg::REG_FILL_LEN)   ? len_rd :
      (ADDR == rsfb_pkg::REG_FIFO_DATA)  ? (empty ? rsfb_pkg::BYTE_ZERO : mem_q[rptr_q]) :
      (ADDR == rsfb_pkg::REG_EVENT0)     ? {4'h0, ev_q} :
      (ADDR == rsfb_pkg::REG_EVENT_EN0)  ? {4'h0, en_q} :
      (ADDR == rsfb_pkg::REG_SM_CTRL)    ? {7'h00, sm_act_q} :
      rsfb_pkg::BYTE_ZERO;
  wire [3:0]  ev_set  = {hi_rise, lo_rise, ovl, 1'b0};
  wire [3:0]  ev_clr  = (WR && ADDR == rsfb_pkg::REG_EVENT0) ? WDATA[3:0] : 4'h0;

  // ==========================================================
  // Buffer storage, no reset needed on data
  always_ff @(posedge CLK)
  begin
    if (push)
    begin
      mem_q[wptr_q] <= push_d;
    end
  end

  // Pointers and fill count
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      wptr_q  <= 9'h000;
      rptr_q  <= 9'h000;
      count_q <= 10'h000;
    end
    else if (flush)
    begin
      wptr_q  <= 9'h000;
      rptr_q  <= 9'h000;
      count_q <= 10'h000;
    end
    else
    begin
      if (push)
        wptr_q <= ptr_inc(wptr_q, short_q);
      if (pop)
        rptr_q <= ptr_inc(rptr_q, short_q);
      count_q <= count_q + {9'h000, push} - {9'h000, pop};
    end
  end

  // Configuration registers
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      short_q  <= 1'b0;
      thresh_q <= rsfb_pkg::THRESH_RST;
      en_q     <= 4'h0;
      sm_act_q <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        short_q     <= WDATA[rsfb_pkg::CTRL_SIZE_BIT];
        thresh_q[8] <= WDATA[rsfb_pkg::CTRL_THRESH_HI];
      end
      if (WR && ADDR == rsfb_pkg::REG_THRESH_LOW)
        thresh_q[7:0] <= WDATA;
      if (WR && ADDR == rsfb_pkg::REG_EVENT_EN0)
        en_q <= WDATA[3:0];
      if (WR && ADDR == rsfb_pkg::REG_SM_CTRL)
        sm_act_q <= WDATA[0];
    end
  end

  // Flags, sticky events (set wins over clear) and interrupt
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      hi_q  <= 1'b0;
      lo_q  <= 1'b1;
      ev_q  <= 4'h0;
      irq_q <= 1'b0;
    end
    else
    begin
      hi_q  <= hi_d;
      lo_q  <= lo_d;
      ev_q  <= (ev_q & ~ev_clr) | ev_set;
      irq_q <= |(((ev_q & ~ev_clr) | ev_set) & en_q);
    end
  end

  // Read data registers, valid the cycle after the strobe
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      rdata_q <= rsfb_pkg::BYTE_ZERO;
      smrd_q  <= rsfb_pkg::BYTE_ZERO;
    end
    else
    begin
      rdata_q <= RD ? rd_mux : rsfb_pkg::BYTE_ZERO;
      smrd_q  <= pop_s ? mem_q[rptr_q] : smrd_q;
    end
  end

  assign RDATA     = rdata_q;
  assign SM_RDATA  = smrd_q;
  assign SM_ACTIVE = sm_act_q;
  assign IRQ       = irq_q;

  // ==========================================================
  // Checks
  AST_FLUSH: assert property (@(posedge CLK) disable iff (!RST_B)
    flush |=> count_q == 10'h000) else $error("flush did not clear count");
  AST_COUNT_UP: assert property (@(posedge CLK) disable iff (!RST_B)
    (push && !pop && !flush) |=> count_q == $past(count_q) + 10'h001)
    else $error("count did not rise");
  AST_COUNT_DN: assert property (@(posedge CLK) disable iff (!RST_B)
    (pop && !push && !flush) |=> count_q == $past(count_q) - 10'h001)
    else $error("count did not fall");
  AST_LIMIT: assert property (@(posedge CLK) disable iff (!RST_B)
    short_q |-> count_q <= 10'h0ff || $past(!short_q)) else $error("short depth exceeded");
  AST_HI: assert property (@(posedge CLK) disable iff (!RST_B)
    ##1 hi_q == $past(hi_d)) else $error("almost full wrong");
  AST_LO: assert property (@(posedge CLK) disable iff (!RST_B)
    (lo_q && !$past(lo_q)) |-> $past(count_q <= {1'b0, thresh_q}))
    else $error("almost empty wrong");
  AST_OVL: assert property (@(posedge CLK) disable iff (!RST_B)
    ovl |=> ev_q[rsfb_pkg::EV_ERR_BIT]) else $error("overflow not flagged");
  AST_IRQ: assert property (@(posedge CLK) disable iff (!RST_B)
    (hi_rise && en_q[rsfb_pkg::EV_HI_BIT]) |=> IRQ) else $error("no interrupt");
  AST_IRQ_LO: assert property (@(posedge CLK) disable iff (!RST_B)
    (lo_rise && en_q[rsfb_pkg::EV_LO_BIT]) |=> IRQ) else $error("no interrupt lo");
  COV_FULL: cover property (@(posedge CLK) disable iff (!RST_B) full);
  COV_OVL: cover property (@(posedge CLK) disable iff (!RST_B) ovl);
  COV_FLUSH: cover property (@(posedge CLK) disable iff (!RST_B) flush && !empty);
  COV_HI_RISE: cover property (@(posedge CLK) disable iff (!RST_B) hi_rise);
  COV_SM_POP: cover property (@(posedge CLK) disable iff (!RST_B) pop_s);

  // ==========================================================
  // Further checks on fill, flags and the host read path

  // Almost-empty follows its equation one cycle later
  AST_LO_NOW: assert property (@(posedge CLK) disable iff (!RST_B)
    ##1 lo_q == $past(lo_d)) else $error("almost empty late");

  // Flush returns both pointers to the start
  AST_FLUSH_PTR: assert property (@(posedge CLK) disable iff (!RST_B)
    flush |=> (wptr_q == 9'h000) && (rptr_q == 9'h000))
    else $error("flush left pointers");

  // A refused write must not change the fill
  AST_OVL_HOLD: assert property (@(posedge CLK) disable iff (!RST_B)
    (ovl && !SM_RD) |=> count_q == $past(count_q))
    else $error("overflow changed count");

  // Threshold low byte takes the written value
  AST_THRESH: assert property (@(posedge CLK) disable iff (!RST_B)
    (WR && ADDR == rsfb_pkg::REG_THRESH_LOW) |=> thresh_q[7:0] == $past(WDATA))
    else $error("threshold not written");

  // Read data rest at zero when no read was asked for
  AST_RDATA_IDLE: assert property (@(posedge CLK) disable iff (!RST_B)
    !RD |=> RDATA == rsfb_pkg::BYTE_ZERO) else $error("read data not idle");

  // The fill never passes the largest depth
  AST_COUNT_MAX: assert property (@(posedge CLK) disable iff (!RST_B)
    count_q <= rsfb_pkg::DEPTH_LONG) else $error("fill beyond depth");

  // Without traffic the fill stands still
  AST_COUNT_HOLD: assert property (@(posedge CLK) disable iff (!RST_B)
    (!push && !pop && !flush) |=> count_q == $past(count_q))
    else $error("fill moved by itself");

  // An almost-full event stays until software clears it
  AST_EV_STICKY: assert property (@(posedge CLK) disable iff (!RST_B)
    (ev_q[rsfb_pkg::EV_HI_BIT] && !ev_clr[rsfb_pkg::EV_HI_BIT])
    |=> ev_q[rsfb_pkg::EV_HI_BIT]) else $error("event lost");
endmodule
`default_nettype wire

// file: hw/rsfb_pkg.sv
// Constants and register map of the shared reader FIFO buffer
`default_nettype none
package rsfb_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [6:0] REG_FIFO_CTRL   = 7'h02; // buffer_control_reg
  localparam logic [6:0] REG_THRESH_LOW  = 7'h03; // threshold_level_low
  localparam logic [6:0] REG_FIFO_DATA   = 7'h05;
  localparam logic [6:0] REG_FILL_LEN    = 7'h04;
  localparam logic [6:0] REG_EVENT0      = 7'h06; // event_reg_zero
  localparam logic [6:0] REG_EVENT_EN0   = 7'h08; // event_enable_reg_zero
  localparam logic [6:0] REG_SM_CTRL     = 7'h0a;
  // ==========================================================
  // Field positions of buffer_control_reg
  localparam int CTRL_SIZE_BIT   = 7; // short_buffer_select
  localparam int CTRL_HI_BIT     = 6; // almost_full_flag
  localparam int CTRL_LO_BIT     = 5; // almost_empty_flag
  localparam int CTRL_FLUSH_BIT  = 4; // buffer_flush_bit
  localparam int CTRL_THRESH_HI  = 2; // threshold high bit
  localparam int CTRL_LEN_HI     = 0; // fill count high bit
  // Event bits of event_reg_zero and its enable
  localparam int EV_HI_BIT  = 3;
  localparam int EV_LO_BIT  = 2;
  localparam int EV_ERR_BIT = 1; // error_event
  // ==========================================================
  // Sizes and reset values
  localparam logic [9:0] DEPTH_LONG  = 10'h200;
  localparam logic [9:0] DEPTH_SHORT = 10'h0ff;
  localparam logic [8:0] THRESH_RST  = 9'h008;
  localparam logic [7:0] BYTE_ZERO   = 8'h00;
endpackage
`default_nettype wire

// file: testbench/rsfb_host.sv
// Host microcontroller model driving the register port of the buffer
`default_nettype none
module rsfb_host (
  // Clock
  input  wire logic       clk,
  // Register port
  output var  logic [6:0] addr,
  output var  logic [7:0] wdata,
  output var  logic       wr,
  output var  logic       rd,
  input  wire logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Bus cycles; strobes last one cycle and change right after an edge
  initial
  begin
    addr = 7'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end
  // Write cycle; the host does not wait for a running command before touching data
  task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so sample there
  task automatic rd_reg(input logic [6:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
endmodule
`default_nettype wire

// file: testbench/tb_rsfb_top.sv
// Self-checking bench of the shared buffer with a host model
`default_nettype none
module tb_rsfb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Signals
  logic       clk;
  logic       rst_b;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       sm_rd;
  logic       sm_wr;
  logic [7:0] sm_wdata;
  logic [7:0] sm_rdata;
  logic       sm_active;
  logic       irq;
  logic [7:0] v;
  logic [31:0] lfsr;
  logic [7:0] q[$];
  int         miscompares;
  int         total_checks;
  // ==========================================================
  // Design and host model
  rsfb_top u_dut (.CLK(clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .SM_WR(sm_wr), .SM_WDATA(sm_wdata), .SM_RD(sm_rd), .SM_RDATA(sm_rdata),
    .SM_ACTIVE(sm_active), .IRQ(irq));
  rsfb_host u_host (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  // Clock of 40 ns
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ==========================================================
  // Helpers
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [6:0] a, input logic [7:0] exp);
    u_host.rd_reg(a, v);
    chk(v, exp);
  endtask
  // Push n random bytes, keeping the expected order in the queue
  task automatic push(input int n);
    for (int i = 0; i < n; i++)
    begin
      lfsr = next_rand(lfsr);
      q.push_back(lfsr[7:0]);
      u_host.wr_reg(rsfb_pkg::REG_FIFO_DATA, lfsr[7:0]);
    end
    repeat (3) @(posedge clk);
  endtask
  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Watchdog far beyond the roughly 1650 cycles of the sequence
  initial
  begin
    #(40 * 20000);
    miscompares++;
    stop_test();
  end
  // ==========================================================
  // Main sequence
  initial
  begin
    miscompares = 0;
    total_checks = 0;
    lfsr = 32'h9e3a;
    rst_b = 1'b0;
    sm_rd = 1'b0;
    sm_wr = 1'b0;
    sm_wdata = 8'h00;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    rchk(rsfb_pkg::REG_FIFO_CTRL, 8'h20);
    rchk(rsfb_pkg::REG_THRESH_LOW, 8'h08);
    rchk(rsfb_pkg::REG_FILL_LEN, 8'h00);
    $display("reset test done");
    u_host.wr_reg(rsfb_pkg::REG_THRESH_LOW, 8'h04);
    push(5);
    rchk(rsfb_pkg::REG_FILL_LEN, 8'h05);
    rchk(rsfb_pkg::REG_FIFO_CTRL, 8'h00);
    // The internal machine pops the oldest byte
    @(posedge clk);
    sm_rd <= 1'b1;
    @(posedge clk);
    sm_rd <= 1'b0;
    @(posedge clk);
    chk(sm_rdata, q.pop_front());
    while (q.size() > 0)
      rchk(rsfb_pkg::REG_FIFO_DATA, q.pop_front());
    rchk(rsfb_pkg::REG_FILL_LEN, 8'h00);
    // The internal machine pushes a byte that the host then reads
    @(posedge clk);
    sm_wr <= 1'b1;
    sm_wdata <= 8'h3c;
    @(posedge clk);
    sm_wr <= 1'b0;
    rchk(rsfb_pkg::REG_FIFO_DATA, 8'h3c);
    rchk(rsfb_pkg::REG_FILL_LEN, 8'h00);
    $display("order test done");
    // Long mode filled to 512 then one byte too many
    push(512);
    rchk(rsfb_pkg::REG_FIFO_CTRL, 8'h40);
    rchk(rsfb_pkg::REG_FILL_LEN, 8'h00);
    u_host.wr_reg(rsfb_pkg::REG_FIFO_DATA, 8'h5a);
    rchk(rsfb_pkg::REG_EVENT0, 8'h0e);
    $display("long fill test done");
    // Short mode after a flush, events cleared once the flags settle
    u_host.wr_reg(rsfb_pkg::REG_FIFO_CTRL, 8'h90);
    q.delete();
    repeat (3) @(posedge clk);
    rchk(rsfb_pkg::REG_EVENT0, 8'h0e);
    u_host.wr_reg(rsfb_pkg::REG_EVENT0, 8'h0e);
    push(256);
    rchk(rsfb_pkg::REG_FILL_LEN, 8'hff);
    rchk(rsfb_pkg::REG_FIFO_CTRL, 8'hc0);
    rchk(rsfb_pkg::REG_EVENT0, 8'h0a);
    chk({7'h00, irq}, 8'h00);
    u_host.wr_reg(rsfb_pkg::REG_EVENT_EN0, 8'h08);
    repeat (2) @(posedge clk);
    chk({7'h00, irq}, 8'h01);
    u_host.wr_reg(rsfb_pkg::REG_EVENT0, 8'h0e);
    repeat (2) @(posedge clk);
    chk({7'h00, irq}, 8'h00);
    $display("short fill test done");
    // Flush empties the buffer at once
    u_host.wr_reg(rsfb_pkg::REG_FIFO_CTRL, 8'h90);
    repeat (3) @(posedge clk);
    rchk(rsfb_pkg::REG_FILL_LEN, 8'h00);
    rchk(rsfb_pkg::REG_FIFO_CTRL, 8'ha0);
    rchk(7'h7f, 8'h00);
    u_host.wr_reg(rsfb_pkg::REG_SM_CTRL, 8'h01);
    repeat (2) @(posedge clk);
    chk({7'h00, sm_active}, 8'h01);
    $display("flush test done");
    stop_test();
  end
endmodule
`default_nettype wire
